// [rtl/cbt_pkg.sv]
package cbt_pkg;

  // Clock
  localparam int CLK_PERIOD_NS = 40;

  // Mode register addresses
  localparam logic [5:0] MR_TERM_ADDR = 6'h0B;
  localparam logic [5:0] MR_VREF_ADDR = 6'h0C;
  localparam logic [5:0] MR_TRAIN_ADDR = 6'h0D;

  // Field positions
  localparam int OP_BANK_BIT = 7;
  localparam int WR_BANK_BIT = 6;
  localparam int TRAIN_EN_BIT = 0;
  localparam int VREF_RANGE_BIT = 6;

  // Widths
  localparam int VREF_W = 7;
  localparam int ODT_W = 3;
  localparam int CA_W = 6;
  localparam int DQ_W = 8;
  localparam int CNT_W = 4;

  // Reset values
  localparam logic [7:0] TRAINING_CONTROL_MODE_REGISTER_RST = 8'h00;
  localparam logic [6:0] CA_VREF_MODE_REGISTER_RST = 7'h4D;
  localparam logic [2:0] TERMINATION_MODE_REGISTER_RST = 3'h0;

  // Times in ns
  localparam int MODE_REG_SET_DELAY_NS = 20;
  localparam int MODE_WRITE_DELAY_NS = 20;
  localparam int TRAIN_ENTRY_DELAY_NS = 250;
  localparam int ASYNC_ECHO_DELAY_NS = 20;

  // Least time rounds up, longest rounds down, never below one cycle
  localparam int MRD_CYC = (MODE_REG_SET_DELAY_NS + CLK_PERIOD_NS - 1)
                           / CLK_PERIOD_NS;
  localparam int MRW_CYC = (MODE_WRITE_DELAY_NS + CLK_PERIOD_NS - 1)
                           / CLK_PERIOD_NS;
  localparam int ENTRY_CYC = (TRAIN_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1)
                             / CLK_PERIOD_NS;
  localparam int ECHO_CYC_RAW = ASYNC_ECHO_DELAY_NS / CLK_PERIOD_NS;
  localparam int ECHO_CYC = (ECHO_CYC_RAW < 1) ? 1 : ECHO_CYC_RAW;

  // Counts and windows
  localparam int STROBE_EDGES_MIN = 2;
  localparam int VALID_WINDOW_DEF = 4;

  typedef enum logic [2:0] {
    ST_NORMAL,
    ST_ARMED,
    ST_TRAIN,
    ST_EXIT,
    ST_LEAVE
  } train_state_type;

endpackage

// [rtl/train_if.sv]
`timescale 1ns/1ps
interface train_if;
  import cbt_pkg::*;
  logic vref_en;
  logic dqs;
  logic [VREF_W-1:0] dq_in;
  logic [VREF_W-1:0] vref_tmp;
  logic vref_tmp_ok;
  logic echo_en;
  logic cs;
  logic [CA_W-1:0] ca;
  logic [DQ_W-1:0] echo_dq;
  logic echo_drive;

  modport ctrl (output vref_en, dqs, dq_in, echo_en, cs, ca,
                input vref_tmp, vref_tmp_ok, echo_dq, echo_drive);
  modport strobe (input vref_en, dqs, dq_in,
                  output vref_tmp, vref_tmp_ok);
  modport echo (input echo_en, cs, ca, output echo_dq, echo_drive);
endinterface

// [rtl/vref_strobe_capture.sv]
`timescale 1ns/1ps
module vref_strobe_capture
  import cbt_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Link to controller
  train_if.strobe tif
);

  logic dqs_q, dqs_d;
  logic [1:0] edges_q, edges_d;
  logic [VREF_W-1:0] val_q, val_d;
  logic ok_q, ok_d;
  logic edge_seen;

  always_comb begin
    dqs_d = tif.dqs;
    edge_seen = tif.vref_en && (tif.dqs != dqs_q);
    edges_d = edges_q;
    val_d = val_q;
    ok_d = ok_q;
    if (!tif.vref_en) begin // [RULE14]
      edges_d = 2'h0;
      ok_d = 1'b0;
    end else if (edge_seen) begin
      // First edge may be unstable; later edges overwrite
      val_d = tif.dq_in; // [RULE15]
      if (edges_q != 2'h3) begin
        edges_d = edges_q + 2'h1;
      end
      if (edges_q >= 2'(STROBE_EDGES_MIN - 1)) begin
        ok_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dqs_q <= 1'b0;
      edges_q <= 2'h0;
      val_q <= 7'h00;
      ok_q <= 1'b0;
    end else begin
      dqs_q <= dqs_d;
      edges_q <= edges_d;
      val_q <= val_d;
      ok_q <= ok_d;
    end
  end

  assign tif.vref_tmp = val_q;
  assign tif.vref_tmp_ok = ok_q;

  a_vref_capture: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    edge_seen |=> val_q == $past(tif.dq_in)) // [RULE15]
    else $error("strobe edge did not capture data pins");

  a_capture_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !tif.vref_en |=> !ok_q) // [RULE14]
    else $error("vref value accepted outside capture phase");

endmodule

// [rtl/ca_echo.sv]
`timescale 1ns/1ps
module ca_echo
  import cbt_pkg::*;
#(
  parameter int VALID_WINDOW = VALID_WINDOW_DEF
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Link to controller
  train_if.echo tif
);

  logic [CA_W-1:0] ca_q, ca_d;
  logic [CNT_W-1:0] win_q, win_d;
  logic tog_q, tog_d;
  logic drive_d;

  // Outputs are next values; the caller registers them
  always_comb begin
    ca_d = ca_q;
    win_d = win_q;
    drive_d = 1'b0;
    if (tif.echo_en && tif.cs) begin // [RULE11]
      ca_d = tif.ca;
      win_d = CNT_W'(VALID_WINDOW - 1);
      drive_d = 1'b1;
    end else if (tif.echo_en && win_q != '0) begin
      win_d = win_q - 1'b1;
      drive_d = 1'b1;
    end else if (!tif.echo_en) begin
      win_d = '0;
    end
    tog_d = drive_d ? !tog_q : tog_q; // [RULE13]
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ca_q <= 6'h00;
      win_q <= 4'h0;
      tog_q <= 1'b0;
    end else begin
      ca_q <= ca_d;
      win_q <= win_d;
      tog_q <= tog_d;
    end
  end

  // Pin 6 carries no meaning while driven
  assign tif.echo_dq = {tog_d, 1'b0, ca_d}; // [RULE12]
  assign tif.echo_drive = drive_d;

  a_window_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (tif.echo_en && tif.cs) |=> win_q == CNT_W'(VALID_WINDOW - 1))
    else $error("valid window length wrong"); // [RULE11]

endmodule

// [rtl/ca_bus_training.sv]
`timescale 1ns/1ps
// How it works
// [RULE1] Power-up selects operating bank zero
// [RULE2] Controller sets write bank one first
// [RULE3] Clock enable low swaps to alternate bank
// [RULE4] Clock enable high restores original bank
// [RULE5] Trained reference values are not retained
// [RULE6] Controller selects this variant via bit seven
// [RULE7] Mode writes set training enable bit
// [RULE8] Clock enable low only after set delay
// [RULE9] Strobes capture data pins; termination stays on
// [RULE10] Pins five to zero input level
// [RULE11] Pins five to zero echo captured command
// [RULE12] Pin six range in, meaningless out
// [RULE13] Pin seven toggles during valid window
// [RULE14] Reference accepted after entry delay only
// [RULE15] Data pin n maps to bit n
// [RULE16] Controller waits long settle before relying
// [RULE17] Latched command values echoed on data
// [RULE18] Clearing enable exits after write delay
// [RULE19] Entry from idle or self refresh
// [RULE20] Single rank: frequency changes around training
// [RULE21] Multi rank: train terminating die first
// [RULE22] Terminating rank termination toggled around training
// [RULE23] Controller writes trained values after exit
// [RULE24] Controller waits 250 ns before patterns
// [RULE25] Echo appears within 20 ns
module ca_bus_training
  import cbt_pkg::*;
#(
  parameter int VALID_WINDOW = VALID_WINDOW_DEF
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Decoded mode write (both parts joined)
  input wire logic mrw_valid_i,
  input wire logic [5:0] mrw_addr_i,
  input wire logic [7:0] mrw_data_i,
  // Command bus
  input wire logic cke_i,
  input wire logic cs_i,
  input wire logic [CA_W-1:0] ca_i,
  // Strobe and data pins
  input wire logic dqs_i,
  input wire logic [DQ_W-1:0] dq_i,
  output logic [DQ_W-1:0] dq_o,
  output logic [DQ_W-1:0] dq_oe_n_o,
  // Status
  output logic op_bank_o,
  output logic write_bank_o,
  output logic training_o,
  output logic ready_o,
  output logic [VREF_W-1:0] vref_o,
  output logic dqs_odt_en_o,
  output logic [ODT_W-1:0] dqs_odt_o
);

  localparam int MRW_CYC_I = MRW_CYC;

  train_if tif ();

  train_state_type state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [7:0] training_control_mode_register_q, training_control_mode_register_d;
  logic entry_done;
  logic mrw_take;
  logic wr13, wr12, wr11;
  logic [VREF_W-1:0] ca_vref_mode_register_w [2];
  logic [ODT_W-1:0] termination_mode_register_w [2];

  logic [DQ_W-1:0] dq_q, dq_d;
  logic [DQ_W-1:0] oe_n_q, oe_n_d;
  logic bank_q, bank_d;
  logic train_q, train_d;
  logic ready_q, ready_d;
  logic [VREF_W-1:0] vref_q, vref_d;
  logic odt_en_q, odt_en_d;
  logic [ODT_W-1:0] odt_q, odt_d;

  // Command decode is off while clock enable is low
  assign mrw_take = mrw_valid_i && cke_i;
  assign wr13 = mrw_take && (mrw_addr_i == MR_TRAIN_ADDR);
  assign wr12 = mrw_take && (mrw_addr_i == MR_VREF_ADDR);
  assign wr11 = mrw_take && (mrw_addr_i == MR_TERM_ADDR);
  assign entry_done = (cnt_q >= CNT_W'(ENTRY_CYC));

  // Per-bank reference and termination registers
  for (genvar b = 0; b < 2; b++) begin : g_bank
    logic [VREF_W-1:0] vref_reg_q, vref_reg_d;
    logic [ODT_W-1:0] odt_reg_q, odt_reg_d;
    logic sel;
    always_comb begin
      sel = (training_control_mode_register_q[WR_BANK_BIT] == 1'(b));
      vref_reg_d = (wr12 && sel) ? mrw_data_i[VREF_W-1:0] : vref_reg_q;
      odt_reg_d = (wr11 && sel) ? mrw_data_i[ODT_W-1:0] : odt_reg_q;
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        vref_reg_q <= CA_VREF_MODE_REGISTER_RST;
        odt_reg_q <= TERMINATION_MODE_REGISTER_RST;
      end else begin
        vref_reg_q <= vref_reg_d;
        odt_reg_q <= odt_reg_d;
      end
    end
    assign ca_vref_mode_register_w[b] = vref_reg_q;
    assign termination_mode_register_w[b] = odt_reg_q;
  end

  // Training sequence
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    training_control_mode_register_d = wr13 ? mrw_data_i : training_control_mode_register_q;
    case (state_q)
      ST_NORMAL: begin
        // Arming needs clock enable high, so not from power down
        if (wr13 && mrw_data_i[TRAIN_EN_BIT]) begin // [RULE19]
          state_d = ST_ARMED;
          cnt_d = '0;
        end
      end
      ST_ARMED: begin
        if (cnt_q < CNT_W'(MRD_CYC)) begin
          cnt_d = cnt_q + 1'b1;
        end
        if (wr13 && !mrw_data_i[TRAIN_EN_BIT]) begin
          state_d = ST_NORMAL;
        end else if (!cke_i && cnt_q >= CNT_W'(MRD_CYC)) begin
          // Early drop of clock enable is not honoured
          state_d = ST_TRAIN; // [RULE3]
          cnt_d = '0;
        end
      end
      ST_TRAIN: begin
        if (!entry_done) begin
          cnt_d = cnt_q + 1'b1;
        end
        if (cke_i) begin
          state_d = ST_EXIT; // [RULE4]
          cnt_d = '0;
        end
      end
      ST_EXIT: begin
        if (wr13 && !mrw_data_i[TRAIN_EN_BIT]) begin
          state_d = ST_LEAVE; // [RULE18]
          cnt_d = '0;
        end else if (!cke_i) begin
          state_d = ST_TRAIN;
          cnt_d = '0;
        end
      end
      ST_LEAVE: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q >= CNT_W'(MRW_CYC - 1)) begin
          state_d = ST_NORMAL; // [RULE18]
          cnt_d = '0;
        end
      end
      default: begin
        state_d = ST_NORMAL;
        cnt_d = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_NORMAL;
      cnt_q <= 4'h0;
      training_control_mode_register_q <= TRAINING_CONTROL_MODE_REGISTER_RST; // [RULE1]
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      training_control_mode_register_q <= training_control_mode_register_d;
    end
  end

  // Sub-block hookup
  assign tif.vref_en = (state_q == ST_TRAIN) && entry_done; // [RULE14]
  assign tif.dqs = dqs_i;
  assign tif.dq_in = dq_i[VREF_W-1:0]; // [RULE15]
  assign tif.echo_en = (state_q == ST_TRAIN) && entry_done;
  assign tif.cs = cs_i;
  assign tif.ca = ca_i;

  vref_strobe_capture u_strobe (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .tif(tif.strobe)
  );

  ca_echo #(
    .VALID_WINDOW(VALID_WINDOW)
  ) u_echo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .tif(tif.echo)
  );

  // Registered pin and status outputs
  always_comb begin
    train_d = (state_d == ST_TRAIN);
    // Alternate bank only while clock enable is low in training
    bank_d = training_control_mode_register_d[OP_BANK_BIT] ^ train_d; // [RULE3] [RULE4]
    ready_d = (state_d == ST_NORMAL);
    // Temporary reference is dropped once training ends
    if (train_d && tif.vref_tmp_ok) begin
      vref_d = tif.vref_tmp; // [RULE14]
    end else begin
      vref_d = ca_vref_mode_register_w[bank_d]; // [RULE5]
    end
    odt_en_d = train_d; // [RULE9]
    odt_d = termination_mode_register_w[bank_d]; // [RULE9]
    // Echo reaches the pins one edge after chip select
    dq_d = tif.echo_dq; // [RULE17] [RULE25]
    oe_n_d = tif.echo_drive ? 8'h00 : 8'hFF; // [RULE10] [RULE11]
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dq_q <= 8'h00;
      oe_n_q <= 8'hFF;
      bank_q <= 1'b0;
      train_q <= 1'b0;
      ready_q <= 1'b1;
      vref_q <= CA_VREF_MODE_REGISTER_RST;
      odt_en_q <= 1'b0;
      odt_q <= TERMINATION_MODE_REGISTER_RST;
    end else begin
      dq_q <= dq_d;
      oe_n_q <= oe_n_d;
      bank_q <= bank_d;
      train_q <= train_d;
      ready_q <= ready_d;
      vref_q <= vref_d;
      odt_en_q <= odt_en_d;
      odt_q <= odt_d;
    end
  end

  assign dq_o = dq_q;
  assign dq_oe_n_o = oe_n_q;
  assign op_bank_o = bank_q;
  assign write_bank_o = training_control_mode_register_q[WR_BANK_BIT];
  assign training_o = train_q;
  assign ready_o = ready_q;
  assign vref_o = vref_q;
  assign dqs_odt_en_o = odt_en_q;
  assign dqs_odt_o = odt_q;

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_entry;
    state_q == ST_ARMED && !cke_i && cnt_q >= CNT_W'(MRD_CYC);
  endsequence

  sequence s_exit_cmd;
    state_q == ST_EXIT && wr13 && !mrw_data_i[TRAIN_EN_BIT];
  endsequence

  a_bank_swap: assert property ( // [RULE3]
    s_entry |=> training_o && op_bank_o != training_control_mode_register_q[OP_BANK_BIT])
    else $error("no bank swap at training entry");

  a_bank_restore: assert property ( // [RULE4]
    (state_q == ST_TRAIN && cke_i) |=>
      !training_o && op_bank_o == training_control_mode_register_q[OP_BANK_BIT])
    else $error("bank not restored at exit");

  a_normal_bank: assert property ( // [RULE1]
    (state_q == ST_NORMAL) |-> op_bank_o == training_control_mode_register_q[OP_BANK_BIT])
    else $error("bank differs from mode register outside training");

  a_vref_discard: assert property ( // [RULE5]
    (state_q == ST_TRAIN && cke_i) |=>
      vref_o == ca_vref_mode_register_w[training_control_mode_register_q[OP_BANK_BIT]])
    else $error("trained reference retained after exit");

  a_strobe_odt: assert property ( // [RULE9]
    training_o |-> dqs_odt_en_o && dqs_odt_o == termination_mode_register_w[op_bank_o])
    else $error("strobe termination wrong in training");

  a_input_window: assert property ( // [RULE10]
    !tif.echo_en |=> dq_oe_n_o == 8'hFF)
    else $error("data pins driven outside valid window");

  a_echo_timing: assert property ( // [RULE17]
    (tif.echo_en && cs_i) |=>
      dq_oe_n_o == 8'h00 && dq_o[CA_W-1:0] == $past(ca_i))
    else $error("command echo late or wrong");

  a_dq7_toggle: assert property ( // [RULE13]
    (dq_oe_n_o[DQ_W-1] == 1'b0 && tif.echo_drive) |=>
      dq_o[DQ_W-1] != $past(dq_o[DQ_W-1]))
    else $error("pin seven did not toggle in window");

  a_exit_ready: assert property ( // [RULE18]
    s_exit_cmd |-> !ready_o ##MRW_CYC_I (state_q == ST_LEAVE)
      ##1 (state_q == ST_NORMAL && ready_o))
    else $error("ready not reached after mode write delay");

  // Capture opens only a full entry delay after training began
  a_entry_wait: assert property ( // [RULE14]
    $rose(tif.vref_en) |-> $past(training_o, ENTRY_CYC))
    else $error("reference accepted before entry delay");

endmodule

// [tb/ctl_model.sv]
`timescale 1ns/1ps
module ctl_model
  import cbt_pkg::*;
#(
  parameter int SETTLE_CYC = 2
) (
  // Clock
  input wire logic clk_i,
  // Mode writes
  output logic mrw_valid_o,
  output logic [5:0] mrw_addr_o,
  output logic [7:0] mrw_data_o,
  // Command bus
  output logic cke_o,
  output logic cs_o,
  output logic [CA_W-1:0] ca_o,
  // Strobe and data
  output logic dqs_o,
  output logic [DQ_W-1:0] dq_o
);
  initial begin
    mrw_valid_o = 1'b0;
    mrw_addr_o = 6'h00;
    mrw_data_o = 8'h00;
    cke_o = 1'b1;
    cs_o = 1'b0;
    ca_o = 6'h00;
    dqs_o = 1'b0;
    dq_o = 8'h00;
  end

  // Released lines show the inverse so stale values cannot pass
  task automatic mode_write(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_i);
    mrw_valid_o <= 1'b1;
    mrw_addr_o <= a;
    mrw_data_o <= d;
    @(posedge clk_i);
    mrw_valid_o <= 1'b0;
    mrw_addr_o <= ~a;
    mrw_data_o <= ~d;
    repeat (MRW_CYC + 1) @(posedge clk_i);
  endtask

  task automatic set_cke(input logic v);
    @(posedge clk_i);
    cke_o <= v;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic strobe(input logic [6:0] p);
    @(posedge clk_i);
    dq_o <= {~dq_o[7], p};
    dqs_o <= ~dqs_o;
    @(posedge clk_i);
    dqs_o <= ~dqs_o;
    @(posedge clk_i);
    dq_o <= ~dq_o;
  endtask

  task automatic cs_pulse(input logic [5:0] c);
    repeat (SETTLE_CYC) @(posedge clk_i);
    @(posedge clk_i);
    cs_o <= 1'b1;
    ca_o <= c;
    @(posedge clk_i);
    cs_o <= 1'b0;
    ca_o <= ~c;
  endtask
endmodule

// [tb/test_ca_bus_training.sv]
`timescale 1ns/1ps
module test_ca_bus_training
  import cbt_pkg::*;
;
  localparam int VW = 4;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic mrw_valid, cke, cs, dqs;
  logic [5:0] mrw_addr;
  logic [7:0] mrw_data;
  logic [CA_W-1:0] ca;
  logic [DQ_W-1:0] ctl_dq, dut_dq, dut_oe, dq_w;
  logic op_bank_o, write_bank_o, training_o, ready_o, dqs_odt_en_o;
  logic [VREF_W-1:0] vref_o;
  logic [ODT_W-1:0] dqs_odt_o;
  logic [6:0] vr[2];
  logic [2:0] od[2];
  integer seed = 32'hEDD0;
  int n_mismatch = 0;
  int compares = 0;

  always #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;
  // Wire level: device wins where it drives
  assign dq_w = (dut_dq & ~dut_oe) | (ctl_dq & dut_oe);

  ctl_model ctl_u (.clk_i(clk_i), .mrw_valid_o(mrw_valid),
    .mrw_addr_o(mrw_addr), .mrw_data_o(mrw_data), .cke_o(cke),
    .cs_o(cs), .ca_o(ca), .dqs_o(dqs), .dq_o(ctl_dq));

  ca_bus_training #(.VALID_WINDOW(VW)) dut_u (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .mrw_valid_i(mrw_valid), .mrw_addr_i(mrw_addr),
    .mrw_data_i(mrw_data), .cke_i(cke), .cs_i(cs), .ca_i(ca),
    .dqs_i(dqs), .dq_i(dq_w), .dq_o(dut_dq), .dq_oe_n_o(dut_oe),
    .op_bank_o(op_bank_o), .write_bank_o(write_bank_o),
    .training_o(training_o), .ready_o(ready_o), .vref_o(vref_o),
    .dqs_odt_en_o(dqs_odt_en_o), .dqs_odt_o(dqs_odt_o));

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    compares++;
    if (e !== g) begin
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask

  task automatic test_done();
    $display("compares %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic echo(input logic [5:0] c);
    int k;
    int n;
    logic t;
    ctl_u.cs_pulse(c);
    #1;
    k = 0;
    while (dut_oe !== 8'h00 && k < 4) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    // Driven in the cycle right after the capturing edge
    chk("echo_delay", 8'h00, 8'(k));
    chk("echo_oe", 8'h00, dut_oe);
    chk("echo_ca", {2'b00, c}, {2'b00, dut_dq[5:0]});
    t = dut_dq[7];
    n = 1;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i);
      #1;
      if (dut_oe === 8'h00) begin
        chk("flag_toggle", {7'h00, ~t}, {7'h00, dut_dq[7]});
        t = dut_dq[7];
        n++;
      end
    end
    chk("echo_window", 8'(VW), 8'(n));
    chk("echo_off", 8'hFF, dut_oe);
  endtask

  // One full pass; the start bank alternates between passes
  task automatic train(input logic b);
    logic nb;
    logic [6:0] p;
    nb = ~b;
    for (int j = 0; j < 2; j++) begin
      ctl_u.mode_write(MR_TRAIN_ADDR, {b, j[0] ^ b, 6'h00});
      vr[j[0] ^ b] = 7'($random(seed));
      od[j[0] ^ b] = 3'($random(seed));
      ctl_u.mode_write(MR_VREF_ADDR, {1'b1, vr[j[0] ^ b]});
      ctl_u.mode_write(MR_TERM_ADDR, {5'h00, od[j[0] ^ b]});
    end
    #1;
    chk("op_bank", {7'h00, b}, {7'h00, op_bank_o});
    chk("write_bank", {7'h00, nb}, {7'h00, write_bank_o});
    chk("vref", {1'b0, vr[b]}, {1'b0, vref_o});
    chk("odt", {5'h00, od[b]}, {5'h00, dqs_odt_o});
    ctl_u.mode_write(MR_TRAIN_ADDR, {b, nb, 6'h01});
    #1;
    chk("ready_armed", 8'h00, {7'h00, ready_o});
    ctl_u.set_cke(1'b0);
    #1;
    chk("training", 8'h01, {7'h00, training_o});
    chk("op_swap", {7'h00, nb}, {7'h00, op_bank_o});
    chk("vref_alt", {1'b0, vr[nb]}, {1'b0, vref_o});
    chk("odt_alt", {5'h00, od[nb]}, {5'h00, dqs_odt_o});
    chk("odt_en", 8'h01, {7'h00, dqs_odt_en_o});
    // Too early: the entry delay has not run out
    ctl_u.strobe(~vr[nb]);
    #1;
    chk("vref_early", {1'b0, vr[nb]}, {1'b0, vref_o});
    repeat (ENTRY_CYC) @(posedge clk_i);
    for (int i = 0; i < 3; i++) begin
      p = (i == 0) ? 7'h7F : 7'($random(seed));
      ctl_u.strobe(p);
      repeat (3) @(posedge clk_i);
      #1;
      chk("vref_cap", {1'b0, p}, {1'b0, vref_o});
      chk("dq_input", 8'hFF, dut_oe);
      echo(6'($random(seed)));
    end
    ctl_u.set_cke(1'b1);
    #1;
    chk("training_off", 8'h00, {7'h00, training_o});
    chk("op_back", {7'h00, b}, {7'h00, op_bank_o});
    chk("vref_back", {1'b0, vr[b]}, {1'b0, vref_o});
    chk("odt_back", {5'h00, od[b]}, {5'h00, dqs_odt_o});
    chk("odt_en_off", 8'h00, {7'h00, dqs_odt_en_o});
    // Enable bit still set: a new low re-enters; writes are ignored
    ctl_u.set_cke(1'b0);
    #1;
    chk("reenter", 8'h01, {7'h00, training_o});
    chk("op_reswap", {7'h00, nb}, {7'h00, op_bank_o});
    ctl_u.mode_write(MR_VREF_ADDR, 8'h00);
    ctl_u.set_cke(1'b1);
    #1;
    chk("op_back2", {7'h00, b}, {7'h00, op_bank_o});
    ctl_u.mode_write(MR_TRAIN_ADDR, {b, nb, 6'h00});
    for (int k = 0; k < 4 && ready_o !== 1'b1; k++) begin
      @(posedge clk_i);
      #1;
    end
    chk("ready", 8'h01, {7'h00, ready_o});
    ctl_u.mode_write(MR_TRAIN_ADDR, {nb, nb, 6'h00});
    #1;
    chk("not_kept", {1'b0, vr[nb]}, {1'b0, vref_o});
    ctl_u.mode_write(MR_VREF_ADDR, {1'b1, p});
    vr[nb] = p;
    #1;
    chk("trained", {1'b0, p}, {1'b0, vref_o});
    $display("test train from bank %0d done", b);
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1;
    chk("rst_op", 8'h00, {7'h00, op_bank_o});
    chk("rst_vref", {1'b0, CA_VREF_MODE_REGISTER_RST}, {1'b0, vref_o});
    chk("rst_oe", 8'hFF, dut_oe);
    chk("rst_ready", 8'h01, {7'h00, ready_o});
    $display("test reset done");
    train(1'b0);
    train(1'b1);
    test_done();
  end

  // Both passes need well under a thousand cycles
  initial begin
    #(CLK_PERIOD_NS * 20000);
    n_mismatch++;
    test_done();
  end
endmodule
